//--- atc_pkg.sv
// Shared constants and types for the address table command port.
package atc_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 16;
   localparam int BE_W = 4;

   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_CMD = 16'h1800;
   localparam logic [15:0] IDX_WR0 = 16'h1801;
   localparam logic [15:0] IDX_WR1 = 16'h1802;
   localparam logic [15:0] IDX_RD0 = 16'h1805;
   localparam logic [15:0] IDX_RD1 = 16'h1806;
   localparam logic [15:0] IDX_STS = 16'h1808;
   localparam logic [15:0] ADDR_CMD = {IDX_CMD[13:0], 2'h0};
   localparam logic [15:0] ADDR_WR0 = {IDX_WR0[13:0], 2'h0};
   localparam logic [15:0] ADDR_WR1 = {IDX_WR1[13:0], 2'h0};
   localparam logic [15:0] ADDR_RD0 = {IDX_RD0[13:0], 2'h0};
   localparam logic [15:0] ADDR_RD1 = {IDX_RD1[13:0], 2'h0};
   localparam logic [15:0] ADDR_STS = {IDX_STS[13:0], 2'h0};

   // Command register bits.
   localparam int CMD_NEXT_BIT = 0;
   localparam int CMD_FIRST_BIT = 1;
   localparam int CMD_MAKE_BIT = 2;
   localparam int CMD_W = 3;

   // Status register bits.
   localparam int STS_PEND_BIT = 0;
   localparam int STS_END_BIT = 1;
   localparam int STS_FULL_BIT = 2;
   localparam int STS_W = 3;

   // Entry layout: word one holds the upper address bytes and attributes.
   localparam int WR1_W = 27;
   localparam int WR1_VALID_BIT = 26;
   localparam int MAC_HI_W = 16;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_CMD = 3'h0;

   localparam int TBL_DEPTH = 64;
   localparam int TBL_IDX_W = 6;
   localparam logic [6:0] PTR_END = 7'h40;
   localparam logic [5:0] IDX_LAST = 6'h3F;

   typedef struct packed {
      logic [WR1_W-1:0] attr;
      logic [DATA_W-1:0] mac_lo;
   } atc_entry_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MAKE_SCAN,
      ST_MAKE_WRITE,
      ST_GET_SCAN,
      ST_DONE
   } atc_state_t;

endpackage

//--- atc_table.sv
// Entry storage of the address lookup table with one write and one read port.
`timescale 1ns/1ps
module atc_table
#(
   parameter int DEPTH = 64,
   parameter int IDX_W = 6
)
(
   input wire logic clk_sys_in, // System clock.
   input wire logic srst_in, // Synchronous reset, clears every entry.
   input wire logic wr_en_in, // Write strobe.
   input wire logic [IDX_W-1:0] wr_idx_in, // Write location.
   input wire atc_pkg::atc_entry_t wr_data_in, // Entry to store.
   input wire logic [IDX_W-1:0] rd_idx_in, // Read location.
   output atc_pkg::atc_entry_t rd_data_out // Entry at read location.
);

   atc_pkg::atc_entry_t mem_r [DEPTH];

   // Clearing on reset leaves no stale valid bits after a restart.
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_r[i] <= '0;
         end
      end
      else if (wr_en_in)
      begin
         mem_r[wr_idx_in] <= wr_data_in;
      end
   end

   assign rd_data_out = mem_r[rd_idx_in];

endmodule

//--- atc_cmd_port.sv
// Command port of the address lookup table, an Avalon-MM slave.
`timescale 1ns/1ps
module atc_cmd_port
(
   input wire logic clk_sys_in, // System clock, 40 MHz.
   input wire logic srst_in, // Synchronous reset, active high.
   input wire logic [15:0] avs_address_in, // Byte address.
   input wire logic avs_read_in, // Read request.
   input wire logic avs_write_in, // Write request.
   input wire logic [3:0] avs_byteenable_in, // Write byte lanes.
   input wire logic [31:0] avs_writedata_in, // Write data.
   output logic [31:0] avs_readdata_out, // Read data.
   output logic avs_waitrequest_out // Stall of the current request.
);

   atc_pkg::atc_state_t state_r;
   atc_pkg::atc_state_t state_nxt;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [2:0] cmd_r;
   logic [2:0] cmd_nxt;
   logic pend_r;
   logic pend_nxt;
   logic end_r;
   logic end_nxt;
   logic full_r;
   logic full_nxt;
   logic [31:0] wr0_r;
   logic [31:0] wr0_nxt;
   logic [26:0] wr1_r;
   logic [26:0] wr1_nxt;
   logic [31:0] rd0_r;
   logic [31:0] rd0_nxt;
   logic [26:0] rd1_r;
   logic [26:0] rd1_nxt;
   logic [5:0] scan_r;
   logic [5:0] scan_nxt;
   // The read pointer holds the slot after the last entry returned, or the end mark.
   logic [6:0] ptr_r;
   logic [6:0] ptr_nxt;
   // Make remembers a matching slot and the first free slot over one full pass.
   logic hit_r;
   logic hit_nxt;
   logic [5:0] hit_idx_r;
   logic [5:0] hit_idx_nxt;
   logic free_r;
   logic free_nxt;
   logic [5:0] free_idx_r;
   logic [5:0] free_idx_nxt;

   // Bus decode. A request is answered one cycle after it appears.
   wire req = avs_read_in | avs_write_in;
   wire take = req & wait_r;
   // A write lands on the acknowledged cycle, after the address has stood a full cycle.
   wire commit_wr = avs_write_in & ~wait_r;
   wire sel_cmd = avs_address_in == atc_pkg::ADDR_CMD;
   wire sel_wr0 = avs_address_in == atc_pkg::ADDR_WR0;
   wire sel_wr1 = avs_address_in == atc_pkg::ADDR_WR1;
   wire sel_rd0 = avs_address_in == atc_pkg::ADDR_RD0;
   wire sel_rd1 = avs_address_in == atc_pkg::ADDR_RD1;
   wire sel_sts = avs_address_in == atc_pkg::ADDR_STS;
   wire [31:0] be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                          {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   wire [31:0] wr0_merge = (wr0_r & ~be_mask) | (avs_writedata_in & be_mask);
   wire [31:0] wr1_merge = ({5'h0, wr1_r} & ~be_mask) | (avs_writedata_in & be_mask);
   // Software words only change on the acknowledged cycle of a write.
   wire wr0_load = commit_wr & sel_wr0;
   wire wr1_load = commit_wr & sel_wr1;

   // Only ones start work; zero bits are dropped here.
   wire [2:0] set_bits = avs_writedata_in[2:0] & {3{avs_byteenable_in[0]}};
   wire idle = state_r == atc_pkg::ST_IDLE;
   wire start = commit_wr & sel_cmd & (|set_bits) & idle;
   // Several bits in one write resolve as make, then get first, then get next.
   wire do_make = set_bits[atc_pkg::CMD_MAKE_BIT];
   wire do_first = set_bits[atc_pkg::CMD_FIRST_BIT];
   wire ptr_spent = ptr_r == atc_pkg::PTR_END;

   // Unused upper bits read as zero so software may compare whole words.
   wire [31:0] cmd_word = {29'h0, cmd_r};
   wire [31:0] wr1_word = {5'h0, wr1_r};
   wire [31:0] rd1_word = {5'h0, rd1_r};
   wire [31:0] sts_word = {29'h0, full_r, end_r, pend_r};
   wire [31:0] rd_mux = sel_cmd ? cmd_word :
                        sel_wr0 ? wr0_r :
                        sel_wr1 ? wr1_word :
                        sel_rd0 ? rd0_r :
                        sel_rd1 ? rd1_word :
                        sel_sts ? sts_word : atc_pkg::RST_WORD;
   // Read data is taken when the request first shows; the answer follows one cycle later.
   wire wait_nxt = ~take;
   wire [31:0] rdata_nxt = take ? rd_mux : rdata_r;

   // Table access. Word zero forms entry bits 31:0, bit 0 the multicast bit.
   atc_pkg::atc_entry_t ent;
   atc_pkg::atc_entry_t new_ent;
   assign new_ent = {wr1_r, wr0_r};
   wire new_valid = wr1_r[atc_pkg::WR1_VALID_BIT];
   wire ent_valid = ent.attr[atc_pkg::WR1_VALID_BIT];
   // Only the address takes part in the match; attributes may differ.
   wire mac_match = (ent.mac_lo == wr0_r) &&
                    (ent.attr[atc_pkg::MAC_HI_W-1:0] == wr1_r[atc_pkg::MAC_HI_W-1:0]);
   wire last = scan_r == atc_pkg::IDX_LAST;
   // The scan index never wraps; the last flag ends every scan first.
   wire [5:0] scan_inc = scan_r + 6'h1;
   wire [6:0] ptr_after = {1'b0, scan_r} + 7'h1;

   // An existing entry wins over a free slot; a cleared valid bit then deletes it.
   wire in_make_write = state_r == atc_pkg::ST_MAKE_WRITE;
   wire tbl_we = in_make_write & (hit_r | (new_valid & free_r));
   wire [5:0] tbl_widx = hit_r ? hit_idx_r : free_idx_r;
   // A valid new address with no free slot is dropped and reported as full.
   wire no_room = new_valid & ~hit_r & ~free_r;

   atc_table #(
      .DEPTH(atc_pkg::TBL_DEPTH),
      .IDX_W(atc_pkg::TBL_IDX_W)
   ) u_table (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .wr_en_in(tbl_we),
      .wr_idx_in(tbl_widx),
      .wr_data_in(new_ent),
      .rd_idx_in(scan_r),
      .rd_data_out(ent)
   );

   // Next-state logic for the command sequencer and software registers.
   always_comb
   begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      pend_nxt = pend_r;
      end_nxt = end_r;
      full_nxt = full_r;
      wr0_nxt = wr0_r;
      wr1_nxt = wr1_r;
      rd0_nxt = rd0_r;
      rd1_nxt = rd1_r;
      scan_nxt = scan_r;
      ptr_nxt = ptr_r;
      hit_nxt = hit_r;
      hit_idx_nxt = hit_idx_r;
      free_nxt = free_r;
      free_idx_nxt = free_idx_r;
      if (wr0_load)
      begin
         wr0_nxt = wr0_merge;
      end
      if (wr1_load)
      begin
         wr1_nxt = wr1_merge[26:0];
      end
      case (state_r)
         atc_pkg::ST_IDLE:
         begin
            if (start)
            begin
               cmd_nxt = set_bits;
               pend_nxt = 1'b1;
               if (do_make)
               begin
                  scan_nxt = 6'h0;
                  hit_nxt = 1'b0;
                  free_nxt = 1'b0;
                  full_nxt = 1'b0;
                  state_nxt = atc_pkg::ST_MAKE_SCAN;
               end
               else if (do_first)
               begin
                  ptr_nxt = 7'h0;
                  scan_nxt = 6'h0;
                  state_nxt = atc_pkg::ST_GET_SCAN;
               end
               else if (ptr_spent)
               begin
                  // A spent pointer answers at once without touching the table.
                  end_nxt = 1'b1;
                  rd0_nxt = atc_pkg::RST_WORD;
                  rd1_nxt = 27'h0;
                  state_nxt = atc_pkg::ST_DONE;
               end
               else
               begin
                  scan_nxt = ptr_r[5:0];
                  state_nxt = atc_pkg::ST_GET_SCAN;
               end
            end
         end
         // Write-data changes while pending would spoil the match; software must wait.
         atc_pkg::ST_MAKE_SCAN:
         begin
            if (ent_valid && mac_match)
            begin
               hit_nxt = 1'b1;
               hit_idx_nxt = scan_r;
            end
            if (!ent_valid && !free_r)
            begin
               free_nxt = 1'b1;
               free_idx_nxt = scan_r;
            end
            if (last)
            begin
               state_nxt = atc_pkg::ST_MAKE_WRITE;
            end
            else
            begin
               scan_nxt = scan_inc;
            end
         end
         atc_pkg::ST_MAKE_WRITE:
         begin
            full_nxt = no_room;
            state_nxt = atc_pkg::ST_DONE;
         end
         atc_pkg::ST_GET_SCAN:
         begin
            if (ent_valid)
            begin
               rd0_nxt = ent.mac_lo;
               rd1_nxt = ent.attr;
               end_nxt = 1'b0;
               ptr_nxt = ptr_after;
               state_nxt = atc_pkg::ST_DONE;
            end
            else if (last)
            begin
               // Nothing valid remains: clear the read words and park the pointer at the end.
               rd0_nxt = atc_pkg::RST_WORD;
               rd1_nxt = 27'h0;
               end_nxt = 1'b1;
               ptr_nxt = atc_pkg::PTR_END;
               state_nxt = atc_pkg::ST_DONE;
            end
            else
            begin
               scan_nxt = scan_inc;
            end
         end
         atc_pkg::ST_DONE:
         begin
            // Pending and the command bits fall on one edge, so polling either is safe.
            cmd_nxt = atc_pkg::RST_CMD;
            pend_nxt = 1'b0;
            state_nxt = atc_pkg::ST_IDLE;
         end
         default:
         begin
            state_nxt = atc_pkg::ST_IDLE;
         end
      endcase
   end

   // Bus handshake: read data is captured when the request first shows.
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         wait_r <= 1'b1;
         rdata_r <= atc_pkg::RST_WORD;
      end
      else
      begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Control state is cleared so the sequencer starts idle.
   // Reset parks the pointer at the table start, so get next then acts as get first.
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         state_r <= atc_pkg::ST_IDLE;
         cmd_r <= atc_pkg::RST_CMD;
         pend_r <= 1'b0;
         end_r <= 1'b0;
         full_r <= 1'b0;
         ptr_r <= 7'h0;
      end
      else
      begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         pend_r <= pend_nxt;
         end_r <= end_nxt;
         full_r <= full_nxt;
         ptr_r <= ptr_nxt;
      end
   end

   // Data registers.
   // The table is cleared by the same reset, so no stale entry survives a restart.
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         wr0_r <= atc_pkg::RST_WORD;
         wr1_r <= 27'h0;
         rd0_r <= atc_pkg::RST_WORD;
         rd1_r <= 27'h0;
         scan_r <= 6'h0;
         hit_r <= 1'b0;
         hit_idx_r <= 6'h0;
         free_r <= 1'b0;
         free_idx_r <= 6'h0;
      end
      else
      begin
         wr0_r <= wr0_nxt;
         wr1_r <= wr1_nxt;
         rd0_r <= rd0_nxt;
         rd1_r <= rd1_nxt;
         scan_r <= scan_nxt;
         hit_r <= hit_nxt;
         hit_idx_r <= hit_idx_nxt;
         free_r <= free_nxt;
         free_idx_r <= free_idx_nxt;
      end
   end

   assign avs_readdata_out = rdata_r;
   assign avs_waitrequest_out = wait_r;

endmodule

//--- atc_cmd_port_sva.sv
// Checker of bus timing and register behaviour for the command port.
`timescale 1ns/1ps
module atc_cmd_port_sva
(
   input wire logic clk_sys_in, // System clock.
   input wire logic srst_in, // Synchronous reset.
   input wire logic [15:0] avs_address_in, // Byte address.
   input wire logic avs_read_in, // Read request.
   input wire logic avs_write_in, // Write request.
   input wire logic [3:0] avs_byteenable_in, // Write lanes.
   input wire logic [31:0] avs_writedata_in, // Write data.
   input wire logic [31:0] avs_readdata_out, // Read data.
   input wire logic avs_waitrequest_out // Stall.
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   wire ack_w = !avs_waitrequest_out;
   wire rd_ack_w = avs_read_in && ack_w;
   wire cmd_wr_w = avs_write_in && ack_w && avs_address_in == atc_pkg::ADDR_CMD;
   wire wr0_wr_w = avs_write_in && ack_w && avs_address_in == atc_pkg::ADDR_WR0;
   wire sts_rd_w = rd_ack_w && avs_address_in == atc_pkg::ADDR_STS;
   wire [31:0] mask_w = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   wire mapped_w = avs_address_in inside {atc_pkg::ADDR_CMD, atc_pkg::ADDR_WR0,
      atc_pkg::ADDR_WR1, atc_pkg::ADDR_RD0, atc_pkg::ADDR_RD1, atc_pkg::ADDR_STS};
   logic idle_r;
   logic [7:0] mk_cnt_r;
   logic [31:0] wr0_r;
   // Idle is set by reset, lost on a command write, and regained once a status read shows no pending work.
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in || cmd_wr_w)
         idle_r <= srst_in;
      else if (sts_rd_w)
         idle_r <= !avs_readdata_out[0];
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in || cmd_wr_w)
         mk_cnt_r <= {7'h00, !srst_in && idle_r && avs_writedata_in[2] && avs_byteenable_in[0]};
      else if (mk_cnt_r != 8'h00 && mk_cnt_r != 8'hC8)
         mk_cnt_r <= mk_cnt_r + 8'h01;
   end
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         wr0_r <= 32'h0000_0000;
      else if (wr0_wr_w)
         wr0_r <= (wr0_r & ~mask_w) | (avs_writedata_in & mask_w);
   end
   rst_idle_a: assert property ($fell(srst_in) |-> avs_waitrequest_out
      && avs_readdata_out == 32'h0000_0000) else $error("bus not idle after reset");
   ack_next_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("request not answered next cycle");
   ack_once_a: assert property (ack_w |-> $past(avs_read_in || avs_write_in)
      ##1 avs_waitrequest_out) else $error("acknowledge without request or too long");
   unmap_zero_a: assert property (rd_ack_w && !mapped_w |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   wr0_echo_a: assert property (rd_ack_w && avs_address_in == atc_pkg::ADDR_WR0
      |-> avs_readdata_out == wr0_r) else $error("write word zero readback wrong");
   wr1_rsvd_a: assert property (rd_ack_w && avs_address_in == atc_pkg::ADDR_WR1
      |-> avs_readdata_out[31:27] == 5'h00) else $error("word one reserved bits set");
   cmd_clear_a: assert property (rd_ack_w && avs_address_in == atc_pkg::ADDR_CMD && idle_r
      |-> avs_readdata_out[2:0] == 3'h0) else $error("command bit left set when idle");
   make_pend_a: assert property (sts_rd_w && mk_cnt_r >= 8'h03 && mk_cnt_r <= 8'h3C
      |-> avs_readdata_out[0]) else $error("pending low during make");
   cover property (cmd_wr_w && avs_writedata_in[1]);
   cover property (sts_rd_w && avs_readdata_out[1]);
   cover property (sts_rd_w && mk_cnt_r == 8'h03);
endmodule
bind atc_cmd_port atc_cmd_port_sva chk_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

//--- atc_cmd_port_tb_top.sv
// Self-checking bench for the command port.
`timescale 1ns/1ps
module atc_cmd_port_tb_top;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   logic [15:0] adr = 16'h0000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [3:0] be = 4'hF;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdata;
   logic wreq;
   logic [31:0] q;
   int fails = 0;
   int check_count = 0;
   always #12.5 clk_sys_in = ~clk_sys_in;
   atc_cmd_port dut_u (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wd),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wreq));
   task automatic summarize();
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic tmo();
      fails++;
      $display("ERROR %0t: timeout", $time);
      summarize();
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] act);
      check_count++;
      if (act !== exp)
      begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   // The request holds until the ack edge, and read data is taken at that edge.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
      input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (wreq !== 1'b0 && n < 20);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (wreq !== 1'b0)
         tmo();
   endtask
   task automatic wt(input logic [15:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hF);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000, 4'hF);
      chk(exp, q);
   endtask
   // Polling is bounded well past the longest command of 66 cycles.
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         xfer(1'b0, atc_pkg::ADDR_STS, 32'h0000_0000, 4'hF);
         n++;
      end
      while (q[0] !== 1'b0 && n < 60);
      if (q[0] !== 1'b0)
         tmo();
   endtask
   task automatic cmd(input logic [2:0] c);
      wt(atc_pkg::ADDR_CMD, {29'h0, c});
      wait_idle();
   endtask
   task automatic mk(input logic [31:0] w0, input logic [31:0] w1);
      wt(atc_pkg::ADDR_WR0, w0);
      wt(atc_pkg::ADDR_WR1, w1);
      cmd(3'h4);
   endtask
   task automatic ent(input logic [31:0] w0, input logic [31:0] w1);
      rdc(atc_pkg::ADDR_RD0, w0);
      rdc(atc_pkg::ADDR_RD1, w1);
   endtask
   task automatic t_reset();
      rdc(atc_pkg::ADDR_CMD, 32'h0000_0000);
      rdc(atc_pkg::ADDR_STS, 32'h0000_0000);
      rdc(atc_pkg::ADDR_WR0, 32'h0000_0000);
   endtask
   task automatic t_regs();
      xfer(1'b1, atc_pkg::ADDR_WR0, 32'hA5C3_9601, 4'h5);
      rdc(atc_pkg::ADDR_WR0, 32'h00C3_0001);
      wt(atc_pkg::ADDR_WR1, 32'hFFFF_FFFF);
      rdc(atc_pkg::ADDR_WR1, 32'h07FF_FFFF);
      wt(16'h0100, 32'h1234_5678);
      rdc(16'h0100, 32'h0000_0000);
      wt(atc_pkg::ADDR_CMD, 32'h0000_0000);
      rdc(atc_pkg::ADDR_STS, 32'h0000_0000);
   endtask
   task automatic t_make();
      wt(atc_pkg::ADDR_WR0, 32'h1234_5601);
      wt(atc_pkg::ADDR_WR1, 32'h0400_ABCD);
      wt(atc_pkg::ADDR_CMD, 32'h0000_0004);
      rdc(atc_pkg::ADDR_STS, 32'h0000_0001);
      rdc(atc_pkg::ADDR_CMD, 32'h0000_0004);
      wt(atc_pkg::ADDR_CMD, 32'h0000_0000);
      rdc(atc_pkg::ADDR_STS, 32'h0000_0001);
      wt(atc_pkg::ADDR_CMD, 32'h0000_0002);
      rdc(atc_pkg::ADDR_CMD, 32'h0000_0004);
      wait_idle();
      rdc(atc_pkg::ADDR_CMD, 32'h0000_0000);
      mk(32'h89AB_CDEE, 32'h0500_1111);
      mk(32'h0BAD_F00C, 32'h0480_2222);
   endtask
   task automatic t_scan();
      cmd(3'h2);
      ent(32'h1234_5601, 32'h0400_ABCD);
      cmd(3'h1);
      ent(32'h89AB_CDEE, 32'h0500_1111);
      cmd(3'h1);
      ent(32'h0BAD_F00C, 32'h0480_2222);
      cmd(3'h1);
      chk(32'h0000_0002, q);
      ent(32'h0000_0000, 32'h0000_0000);
      cmd(3'h1);
      chk(32'h0000_0002, q);
      ent(32'h0000_0000, 32'h0000_0000);
      cmd(3'h2);
      ent(32'h1234_5601, 32'h0400_ABCD);
   endtask
   task automatic t_modify();
      mk(32'h1234_5601, 32'h0540_ABCD);
      mk(32'h89AB_CDEE, 32'h0100_1111);
      cmd(3'h2);
      ent(32'h1234_5601, 32'h0540_ABCD);
      cmd(3'h1);
      ent(32'h0BAD_F00C, 32'h0480_2222);
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      t_reset();
      t_regs();
      t_make();
      t_scan();
      t_modify();
      summarize();
   end
endmodule
